// ===== multichannel_pwm_output_control.sv
// register file, dimming and clock supervision of the pwm output block
`default_nettype none
module multichannel_pwm_output_control
	import pwm_ctrl_pkg::*;
#(
	parameter int NUM_CH = MAX_CH,
	parameter int NUM_INT_CH = MAX_INT_CH,
	parameter int SLOW_LIMIT_CYC = SLOW_LIMIT_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// serial control port
	input wire logic select_n,
	input wire logic sclk,
	input wire logic si,
	// reference clock and mode
	input wire logic ref_clk_in,
	input wire logic fail_mode,
	// switch drive
	output logic [NUM_CH-1:0] channel_state,
	output logic [NUM_CH-1:0] fast_slew,
	output logic clock_fail
);
	// parameter checks
	if (NUM_CH < 1 || NUM_CH > MAX_CH || NUM_INT_CH > NUM_CH ||
		NUM_INT_CH > MAX_INT_CH) begin : g_bad_ch
		$error("channel counts out of range");
	end
	if (SLOW_LIMIT_CYC <= FAST_LIMIT_CYC || SLOW_LIMIT_CYC > 8191) begin : g_bad
		$error("slow limit out of range");
	end

	localparam logic [12:0] SLOW_LIM = 13'(SLOW_LIMIT_CYC);
	localparam logic [12:0] FAST_LIM = 13'(FAST_LIMIT_CYC);

	logic rst_q1;
	logic rst_n;
	spi_word_s word;
	logic word_valid;
	logic [11:0] d;
	ctrl_s st;
	ctrl_s next_st;
	logic [MAX_CH-1:0][7:0] eff_duty;
	logic [NUM_CH-1:0] outs;
	logic no_pwm;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	spi_frame_rx u_rx (
		.clk(clk),
		.rst_n(rst_n),
		.select_n(select_n),
		.sclk(sclk),
		.si(si),
		.word(word),
		.word_valid(word_valid)
	);

	assign d = word[11:0];

	// shared or own duty per channel
	always_comb begin
		for (int i = 0; i < MAX_CH; i++) begin
			eff_duty[i] = st.gsel[i] ? st.gduty : st.duty[i];
		end
	end

	// register writes, dimming steps and reference supervision
	always_comb begin
		logic [8:0] sum;
		logic [7:0] step;
		next_st = st;
		sum = 9'h000;
		step = 8'h00;
		next_st.resync = 1'b0;
		if (word_valid) begin
			unique case (word.addr)
				ADDR_INIT2: begin
					next_st.resync = d[RESYNC_BIT];
				end
				ADDR_OUT_CTRL: begin
					next_st.on[NUM_CH-1:0] = d[NUM_CH-1:0];
				end
				ADDR_GLOBAL: begin
					// sub bit keeps selects and shared duty apart
					if (d[SUBREG_BIT]) begin
						next_st.gduty = word.duty_code;
					end else begin
						next_st.gsel[NUM_CH-1:0] = d[NUM_CH-1:0];
					end
				end
				ADDR_PRESC: begin
					for (int i = 0; i < NUM_CH; i++) begin
						if ((i / PRESC_PER_SUBREG) == int'(d[SUBREG_BIT])) begin
							next_st.presc[i] = d[2*(i%PRESC_PER_SUBREG)+:2];
						end
					end
				end
				ADDR_INCR: begin
					for (int i = 0; i < NUM_INT_CH; i++) begin
						unique case (d[2*i+:2])
							2'h0: step = 8'h00;
							2'h1: step = STEP_SMALL;
							2'h2: step = STEP_MID;
							2'h3: step = STEP_LARGE;
						endcase
						if (d[STEP_SIGN_BIT]) begin
							sum = {1'b0, st.duty[i]} + {1'b0, step};
							next_st.duty[i] = sum[8] ? DUTY_FULL : sum[7:0];
						end else begin
							sum = {1'b0, st.duty[i]} - {1'b0, step};
							next_st.duty[i] = sum[8] ? DUTY_EMPTY : sum[7:0];
						end
					end
				end
				default: begin
					// channel control words live at consecutive addresses
					for (int i = 0; i < NUM_CH; i++) begin
						if (word.addr == ADDR_CH_FIRST + 4'(i)) begin
							next_st.duty[i] = word.duty_code;
							next_st.on[i] = word.on;
							next_st.phase[i] = word.phase;
							next_st.watchdog_bit = word.watchdog_bit;
						end
					end
				end
			endcase
		end
		// period measure between rising edges of the reference clock
		next_st.ref_q = ref_clk_in;
		next_st.ref_tick = 1'b0;
		if (ref_clk_in && !st.ref_q) begin
			next_st.ref_cnt = 13'h0000;
			next_st.fail = (st.ref_cnt < FAST_LIM);
			next_st.ref_tick = (st.ref_cnt >= FAST_LIM);
		end else if (st.ref_cnt >= SLOW_LIM) begin
			next_st.fail = 1'b1;
		end else begin
			next_st.ref_cnt = st.ref_cnt + 13'h0001;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			for (int i = 0; i < MAX_CH; i++) begin
				st.duty[i] <= DUTY_RST;
				st.presc[i] <= PRESC_RST;
				st.phase[i] <= PHASE_RST;
			end
		end else begin
			st <= next_st;
		end
	end

	// fail mode or failed reference clock (silent or too fast): outputs follow the on bits only
	assign no_pwm = fail_mode || st.fail;

	// one generator per channel, own phase and prescaler always
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		pwm_channel u_ch (
			.clk(clk),
			.rst_n(rst_n),
			.ref_tick(st.ref_tick),
			.resync(st.resync),
			.force_full(no_pwm),
			.on(st.on[g]),
			.duty(eff_duty[g]),
			.phase(st.phase[g]),
			.presc(st.presc[g]),
			.out(outs[g])
		);
		assign fast_slew[g] = st.presc[g][1];
	end

	assign channel_state = outs;
	assign clock_fail = st.fail;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// register writes land one cycle after the word arrives
	a_resync_pulse: assert property (
		word_valid && word.addr == ADDR_INIT2
		|=> st.resync == $past(d[RESYNC_BIT]))
		else $error("resync pulse does not follow init2 write");
	a_ch_write: assert property (
		word_valid && word.addr == ADDR_CH_FIRST
		|=> st.duty[0] == $past(word.duty_code) && st.on[0] == $past(word.on))
		else $error("channel word not stored");
	a_watch_store: assert property (
		word_valid && word.addr == ADDR_CH_FIRST
		|=> st.watchdog_bit == $past(word.watchdog_bit))
		else $error("watchdog bit not stored");
	a_out_ctrl: assert property (
		word_valid && word.addr == ADDR_OUT_CTRL
		|=> st.on[NUM_CH-1:0] == $past(d[NUM_CH-1:0]))
		else $error("output control on bits not stored");
	a_gduty_write: assert property (
		word_valid && word.addr == ADDR_GLOBAL && d[SUBREG_BIT]
		|=> st.gduty == $past(word.duty_code) && $stable(st.gsel))
		else $error("shared duty write wrong");
	a_gsel_write: assert property (
		word_valid && word.addr == ADDR_GLOBAL && !d[SUBREG_BIT]
		|=> st.gsel[NUM_CH-1:0] == $past(d[NUM_CH-1:0]) && $stable(st.gduty))
		else $error("global select write wrong");
	a_presc_high: assert property (
		NUM_CH > 3 && word_valid && word.addr == ADDR_PRESC && d[SUBREG_BIT]
		|=> st.presc[3] == $past(d[1:0]))
		else $error("upper prescaler group not stored");
	a_slew_map: assert property (
		word_valid && word.addr == ADDR_PRESC && !d[SUBREG_BIT]
		|=> fast_slew[0] == $past(d[1]))
		else $error("prescaler slew wrong");

	// dimming steps saturate and leave the sixth and shared duty alone
	a_step_up: assert property (
		word_valid && word.addr == ADDR_INCR && d[STEP_SIGN_BIT]
		|=> st.duty[0] >= $past(st.duty[0]))
		else $error("increment wrapped");
	a_step_down: assert property (
		word_valid && word.addr == ADDR_INCR && !d[STEP_SIGN_BIT] &&
		d[1:0] != 2'h0
		|=> st.duty[0] < $past(st.duty[0]) || st.duty[0] == DUTY_EMPTY)
		else $error("decrement wrong");
	a_step_four: assert property (
		word_valid && word.addr == ADDR_INCR && d[STEP_SIGN_BIT] &&
		d[1:0] == 2'h1 && st.duty[0] <= 8'hFB
		|=> st.duty[0] == 8'($past(st.duty[0]) + STEP_SMALL))
		else $error("step of four wrong");
	a_step_none: assert property (
		word_valid && word.addr == ADDR_INCR && d[3:2] == 2'h0
		|=> $stable(st.duty[1]))
		else $error("zero step moved a duty");
	a_sixth_kept: assert property (
		word_valid && word.addr == ADDR_INCR
		|=> $stable(st.duty[MAX_CH-1]) && $stable(st.gduty))
		else $error("step touched sixth or shared duty");
	a_global_pick: assert property (
		st.gsel[4] |-> eff_duty[4] == st.gduty)
		else $error("global select ignored");

	// output timing against the on bits and the period start
	a_off_now: assert property (
		!st.on[0] |=> !channel_state[0])
		else $error("off did not act at once");
	a_full_delay: assert property (
		word_valid && word.addr == ADDR_CH_FIRST && word.on &&
		word.duty_code == DUTY_FULL && !st.gsel[0]
		##1 (!word_valid && !fail_mode) |=> channel_state[0])
		else $error("full duty not applied at once");
	a_resync_start: assert property (
		st.resync && st.on[0] && !no_pwm && st.phase[0] == 2'h0
		|=> channel_state[0])
		else $error("resync did not start a period");
	a_phase_late: assert property (
		st.resync && st.on[1] && !no_pwm && st.phase[1] == 2'h3 &&
		eff_duty[1] < 8'hC0
		|=> !channel_state[1])
		else $error("phase offset not applied");

	// reference clock supervision and fail handling
	a_fast_fail: assert property (
		ref_clk_in && !st.ref_q && st.ref_cnt < FAST_LIM
		|=> st.fail && !st.ref_tick)
		else $error("fast reference clock not flagged");
	a_slow_fail: assert property (
		!(ref_clk_in && !st.ref_q) && st.ref_cnt >= SLOW_LIM
		|=> st.fail)
		else $error("silent reference clock not flagged");
	a_good_edge: assert property (
		ref_clk_in && !st.ref_q && st.ref_cnt >= FAST_LIM
		|=> !st.fail && st.ref_tick)
		else $error("good reference edge not accepted");
	a_fail_full: assert property (
		st.fail && st.on[0] |=> channel_state[0])
		else $error("failed clock does not force full duty");
	a_fail_mode_on: assert property (
		fail_mode && st.on[1] |=> channel_state[1])
		else $error("fail mode still modulates");

	// main scenarios reached
	c_resync: cover property (st.resync);
	c_fail: cover property ($rose(st.fail));
	c_step: cover property (word_valid && word.addr == ADDR_INCR);
	c_global: cover property (st.gsel[4] && channel_state[4]);
	c_fail_mode: cover property (fail_mode && channel_state[0]);
endmodule : multichannel_pwm_output_control
`default_nettype wire

// ===== pwm_ctrl_pkg.sv
// shared constants, field layouts and state carriers for the pwm block
`default_nettype none
package pwm_ctrl_pkg;
	// channel counts
	localparam int MAX_CH = 6;
	localparam int MAX_INT_CH = 5;
	// register addresses carried in the top four bits of a frame
	localparam logic [3:0] ADDR_INIT2 = 4'h1;
	localparam logic [3:0] ADDR_CH_FIRST = 4'h2;
	localparam logic [3:0] ADDR_OUT_CTRL = 4'h8;
	localparam logic [3:0] ADDR_GLOBAL = 4'h9;
	localparam logic [3:0] ADDR_PRESC = 4'hC;
	localparam logic [3:0] ADDR_INCR = 4'hE;
	// field positions inside the 12 data bits
	localparam int RESYNC_BIT = 1;
	localparam int SUBREG_BIT = 11;
	localparam int STEP_SIGN_BIT = 10;
	localparam int PRESC_PER_SUBREG = 3;
	localparam int PHASE_SHIFT = 6;
	// values after reset and duty limits
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [1:0] PRESC_RST = 2'h0;
	localparam logic [1:0] PHASE_RST = 2'h0;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] DUTY_EMPTY = 8'h00;
	// step sizes of incremental dimming
	localparam logic [7:0] STEP_SMALL = 8'h04;
	localparam logic [7:0] STEP_MID = 8'h08;
	localparam logic [7:0] STEP_LARGE = 8'h10;
	// frame length in bits
	localparam logic [4:0] FRAME_BITS = 5'h10;
	// reference clock supervision
	localparam int CLK_HZ = 100_000_000;
	localparam int REF_MIN_HZ = 25_600;
	localparam int REF_MAX_HZ = 102_400;
	localparam int FAIL_MARGIN = 2;
	localparam int REF_PER_MAX_CYC = CLK_HZ / REF_MIN_HZ;
	localparam int REF_PER_MIN_CYC = (CLK_HZ + REF_MAX_HZ - 1) / REF_MAX_HZ;
	localparam int SLOW_LIMIT_DEF = REF_PER_MAX_CYC * FAIL_MARGIN;
	localparam int FAST_LIMIT_CYC = REF_PER_MIN_CYC / FAIL_MARGIN;

	// one received serial frame
	typedef struct packed {
		logic [3:0] addr;
		logic watchdog_bit;
		logic [1:0] phase;
		logic on;
		logic [7:0] duty_code;
	} spi_word_s;

	// receiver state
	typedef struct packed {
		logic sclk_q;
		logic sel_q;
		logic [15:0] shift;
		logic [4:0] cnt;
		spi_word_s word;
		logic valid;
	} rx_s;

	// per channel generator state
	typedef struct packed {
		logic [1:0] pre;
		logic [7:0] cnt;
		logic on_act;
		logic [7:0] duty_act;
		logic out;
	} chan_s;

	// control registers and supervision state
	typedef struct packed {
		logic [MAX_CH-1:0][7:0] duty;
		logic [MAX_CH-1:0] on;
		logic [MAX_CH-1:0][1:0] phase;
		logic [MAX_CH-1:0][1:0] presc;
		logic [MAX_CH-1:0] gsel;
		logic [7:0] gduty;
		logic watchdog_bit;
		logic resync;
		logic ref_q;
		logic [12:0] ref_cnt;
		logic fail;
		logic ref_tick;
	} ctrl_s;
endpackage : pwm_ctrl_pkg
`default_nettype wire

// ===== spi_frame_rx.sv
// 16-bit serial frame receiver, data taken on the falling clock edge
`default_nettype none
module spi_frame_rx
	import pwm_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial pins
	input wire logic select_n,
	input wire logic sclk,
	input wire logic si,
	// received frame
	output spi_word_s word,
	output logic word_valid
);
	rx_s st;
	rx_s next_st;

	// shift while selected, deliver only complete frames on deselect
	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		next_st.sclk_q = sclk;
		next_st.sel_q = select_n;
		if (!select_n && st.sel_q) begin
			next_st.cnt = 5'h00;
		end else if (!select_n && st.sclk_q && !sclk) begin
			next_st.shift = {st.shift[14:0], si};
			if (st.cnt != 5'h1F) begin
				next_st.cnt = st.cnt + 5'h01;
			end
		end
		// any length other than 16 bits is dropped so a glitchy frame cannot corrupt state
		if (select_n && !st.sel_q && st.cnt == FRAME_BITS) begin
			next_st.word = spi_word_s'(st.shift);
			next_st.valid = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.sclk_q <= 1'b0;
			st.sel_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign word = st.word;
	assign word_valid = st.valid;
endmodule : spi_frame_rx
`default_nettype wire

// ===== pwm_channel.sv
// one pwm channel: prescaler, period counter, phase and duty compare
`default_nettype none
module pwm_channel
	import pwm_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// timing
	input wire logic ref_tick,
	input wire logic resync,
	input wire logic force_full,
	// settings
	input wire logic on,
	input wire logic [7:0] duty,
	input wire logic [1:0] phase,
	input wire logic [1:0] presc,
	// switch drive
	output logic out
);
	chan_s st;
	chan_s next_st;
	logic ch_tick;
	logic period_start;
	logic [7:0] phased;

	// divide reference ticks by 4, 2 or 1
	always_comb begin
		next_st = st;
		ch_tick = 1'b0;
		period_start = 1'b0;
		phased = 8'h00;
		if (ref_tick) begin
			next_st.pre = st.pre + 2'h1;
			if (presc[1]) begin
				ch_tick = 1'b1;
			end else if (presc[0]) begin
				ch_tick = st.pre[0];
			end else begin
				ch_tick = (st.pre == 2'h3);
			end
		end
		if (ch_tick) begin
			next_st.cnt = st.cnt + 8'h01;
			period_start = (st.cnt == 8'hFF);
		end
		if (resync) begin
			next_st.pre = 2'h0;
			next_st.cnt = 8'h00;
			period_start = 1'b1;
		end
		// off and full duty act at once, the rest waits for a new period
		if (!on) begin
			next_st.on_act = 1'b0;
		end else if (duty == DUTY_FULL) begin
			next_st.on_act = 1'b1;
			next_st.duty_act = DUTY_FULL;
		end else if (period_start) begin
			next_st.on_act = 1'b1;
			next_st.duty_act = duty;
		end
		// phase staggers the window by quarter periods
		phased = next_st.cnt + {phase, 6'h00};
		if (force_full) begin
			next_st.out = on;
		end else begin
			next_st.out = next_st.on_act && (phased <= next_st.duty_act);
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign out = st.out;
endmodule : pwm_channel
`default_nettype wire

// ===== spi_host_model.sv
// serial host model driving 16-bit frames into the pwm block
`default_nettype none
module spi_host_model (
	// clock
	input wire logic clk,
	// serial pins
	output var logic select_n,
	output var logic sclk,
	output var logic si
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle: deselected, serial clock parked low between frames
	initial begin
		select_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	// one frame, msb first, each serial clock level held two cycles, each data bit four
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		select_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			repeat (2) @(posedge clk);
			si <= w[i];
			sclk <= 1'b1;
			repeat (2) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (2) @(posedge clk);
		select_n <= 1'b1;
		// released data line flips so a stale bit cannot pass
		si <= ~w[0];
		repeat (3) @(posedge clk);
	endtask : send
endmodule : spi_host_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the pwm output block
`default_nettype none
module testbench
	import pwm_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// short silence limit keeps clock-fail detection quick
	localparam int SLOW_CYC = 600;
	logic clk;
	logic arst_n;
	logic fail_mode;
	logic ref_clk_in = 1'b0;
	logic ref_run = 1'b1;
	wire logic select_n;
	wire logic sclk;
	wire logic si;
	logic [5:0] channel_state;
	logic [5:0] fast_slew;
	logic clock_fail;
	int fail_count = 0;
	int checks = 0;
	int ref_half = 260;
	int ref_cnt = 0;

	multichannel_pwm_output_control #(.SLOW_LIMIT_CYC(SLOW_CYC)) dut (
		.clk(clk), .arst_n(arst_n),
		.select_n(select_n), .sclk(sclk), .si(si),
		.ref_clk_in(ref_clk_in), .fail_mode(fail_mode),
		.channel_state(channel_state), .fast_slew(fast_slew),
		.clock_fail(clock_fail)
	);

	spi_host_model host (
		.clk(clk), .select_n(select_n), .sclk(sclk), .si(si)
	);

	// 100 mhz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// reference clock, 520-cycle period; can be stopped or sped up
	always @(posedge clk) begin
		if (ref_run && ref_cnt >= ref_half - 1) begin
			ref_cnt <= 0;
			ref_clk_in <= ~ref_clk_in;
		end else if (ref_run) begin
			ref_cnt <= ref_cnt + 1;
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done();
	end

	task automatic test_done();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check

	// duties stay inside the divide-by-4 range apart from full
	task automatic chan(input int n, input logic [1:0] ph, input logic on,
		input logic [7:0] d);
		host.send({ADDR_CH_FIRST + 4'(n), 1'b0, ph, on, d});
	endtask : chan

	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		host.send({a, d});
	endtask : wr

	// let register and output updates land
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask : settle

	task automatic resync();
		wr(ADDR_INIT2, 12'h002);
		settle();
	endtask : resync

	task automatic t_immediate();
		chan(0, 2'h0, 1'b1, 8'hFF);
		settle();
		check(channel_state[0] === 1'b1, "full duty on late");
		chan(0, 2'h0, 1'b0, 8'hFF);
		settle();
		check(channel_state[0] === 1'b0, "off late");
		chan(1, 2'h0, 1'b0, 8'hFF);
		wr(ADDR_OUT_CTRL, 12'h002);
		settle();
		check(channel_state[1:0] === 2'b10, "shared on ignored");
		wr(ADDR_OUT_CTRL, 12'h000);
		settle();
		check(channel_state[1] === 1'b0, "shared off ignored");
	endtask : t_immediate

	task automatic t_sync();
		chan(0, 2'h0, 1'b1, 8'h80);
		settle();
		check(channel_state[0] === 1'b0, "partial duty early");
		wr(ADDR_INIT2, 12'h000);
		settle();
		check(channel_state[0] === 1'b0, "resync bit clear acted");
		chan(1, 2'h3, 1'b1, 8'h80);
		resync();
		check(channel_state[1:0] === 2'b01, "resync or phase");
	endtask : t_sync

	task automatic t_step();
		chan(0, 2'h3, 1'b1, 8'hC0);
		chan(1, 2'h3, 1'b1, 8'hB8);
		chan(2, 2'h3, 1'b1, 8'hF8);
		chan(3, 2'h1, 1'b1, 8'h08);
		chan(4, 2'h3, 1'b1, 8'h80);
		chan(5, 2'h3, 1'b1, 8'hC0);
		wr(ADDR_GLOBAL, 12'h8C0);
		wr(ADDR_GLOBAL, 12'h010);
		// down: ch1 by 4, ch4 and ch5 by 16, ch2 and ch3 untouched
		wr(ADDR_INCR, 12'h3C1);
		resync();
		check(channel_state[2:0] === 3'b100, "step down");
		check(channel_state[5:3] === 3'b110, "shared untouched");
		// up: ch1 by 4, ch2 by 8, ch3 by 16 into the top rail
		wr(ADDR_INCR, 12'h439);
		resync();
		check(channel_state === 6'b110111, "up");
		wr(ADDR_GLOBAL, 12'h000);
		resync();
		check(channel_state === 6'b100111, "select clear");
	endtask : t_step

	task automatic t_fail();
		@(posedge clk);
		fail_mode <= 1'b1;
		settle();
		check(channel_state === 6'h3F, "fail mode modulates");
		fail_mode <= 1'b0;
		ref_run <= 1'b0;
		repeat (800) @(posedge clk);
		#1;
		check(clock_fail === 1'b1, "silent clock unseen");
		check(channel_state === 6'h3F, "failed clock modulates");
		@(posedge clk);
		ref_run <= 1'b1;
		repeat (1200) @(posedge clk);
		#1;
		check(clock_fail === 1'b0, "good clock still failed");
		ref_half <= 40;
		repeat (300) @(posedge clk);
		#1;
		check(clock_fail === 1'b1, "fast clock unseen");
		ref_half <= 260;
		repeat (1200) @(posedge clk);
	endtask : t_fail

	task automatic t_slew();
		// outputs off before the prescaler moves
		wr(ADDR_OUT_CTRL, 12'h000);
		wr(ADDR_PRESC, 12'h032);
		wr(ADDR_PRESC, 12'h80D);
		settle();
		check(fast_slew === 6'b010101, "slew per prescaler");
		check(channel_state === 6'h00, "off via shared");
	endtask : t_slew

	// reset, then scenarios in order
	initial begin
		arst_n = 1'b0;
		fail_mode = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(channel_state === 6'h00 && clock_fail === 1'b0, "reset out");
		check(fast_slew === 6'h00, "reset slew");
		// release on a rising edge, after three held cycles
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (1200) @(posedge clk);
		t_immediate();
		t_sync();
		t_step();
		t_fail();
		t_slew();
		test_done();
	end
endmodule : testbench
`default_nettype wire
